/* rtl/perp_pkg.sv */
package perp_pkg;

   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [7:0] OFS_P1_RATE     = 8'h19;
   localparam logic [7:0] OFS_P2_RATE     = 8'h29;
   localparam logic [7:0] OFS_P3_RATE     = 8'h39;
   localparam logic [7:0] OFS_P1_PHY      = 8'h1A;
   localparam logic [7:0] OFS_P2_PHY      = 8'h2A;
   localparam logic [7:0] OFS_P3_PHY_RSVD = 8'h3A;
   localparam logic [7:0] OFS_P1_FCNT     = 8'h1B;
   localparam logic [7:0] OFS_P2_FCNT     = 8'h2B;
   localparam logic [7:0] OFS_P3_FCNT_RSV = 8'h3B;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int Q3_LSB     = 4;
   localparam int Q2_LSB     = 0;
   localparam int SHORT_BIT  = 7;
   localparam int RESULT_LSB = 5;
   localparam int EN_BIT     = 4;
   localparam int FLINK_BIT  = 3;
   localparam int PSAVE_BIT  = 2;
   localparam int LOOP_BIT   = 1;
   localparam int CNT8_BIT   = 0;

   // ***************************************************************
   // Reset values and codes
   // ***************************************************************
   localparam logic [7:0]  RATE_RST       = 8'h00;
   localparam logic [3:0]  CODE_UNLIMITED = 4'h0;
   localparam logic [1:0]  RESULT_RST     = 2'h0;
   localparam logic        PSAVE_RST      = 1'b1;
   localparam logic [8:0]  FCNT_RST       = 9'h000;
   localparam logic [16:0] TEN_MEG_KBPS   = 17'h02710;

   typedef enum {PERP_IDLE, PERP_TESTING} perp_diag_t;

   // Limit in Kbps for a rate code; zero stands for unlimited
   function automatic logic [16:0] rate_kbps(input logic [3:0] code);
      logic [16:0] k;
      k = 17'h00000;
      case (code)
         4'h1: k = 17'h00040;
         4'h2: k = 17'h00080;
         4'h3: k = 17'h00100;
         4'h4: k = 17'h00200;
         4'h5: k = 17'h003E8;
         4'h6: k = 17'h007D0;
         4'h7: k = 17'h00FA0;
         4'h8: k = 17'h01F40;
         4'h9: k = 17'h03E80;
         4'hA: k = 17'h07D00;
         4'hB: k = 17'h0BB80;
         4'hC: k = 17'h0FA00;
         4'hD: k = 17'h11940;
         4'hE: k = 17'h13880;
         4'hF: k = 17'h157C0;
         default: k = 17'h00000;
      endcase
      return k;
   endfunction

endpackage

/* rtl/perp_phy_if.sv */
`timescale 1ns/1ps
interface perp_phy_if;
   logic       wr;
   logic [7:0] wdata;
   logic [7:0] status;
   logic [8:0] fault_cnt;
   logic       start;
   logic       done;
   logic [1:0] result;
   logic       short10;
   logic [8:0] cnt_in;
   logic       force_link;
   logic       pwrsave_off;
   logic       remote_loop;

   modport ctl (input wr, wdata, done, result, short10, cnt_in,
                output status, fault_cnt, start, force_link, pwrsave_off, remote_loop);
   modport hub (output wr, wdata, done, result, short10, cnt_in,
                input status, fault_cnt, start, force_link, pwrsave_off, remote_loop);
endinterface // perp_phy_if

/* rtl/perp_rate_map.sv */
`timescale 1ns/1ps
module perp_rate_map (
   input  wire logic [3:0]  code,        // Programmed rate code
   input  wire logic        ten_meg,     // Port runs at 10 Mbps
   input  wire logic        multi_q_en,  // Multiple transmit queues on
   output logic      [16:0] limit_kbps   // Effective limit, 0 = unlimited
);
   logic [16:0] raw;

   always_comb begin
      raw = perp_pkg::rate_kbps(code);
      if (!multi_q_en) begin
         limit_kbps = 17'h00000;
      end else if (ten_meg && raw > perp_pkg::TEN_MEG_KBPS) begin
         limit_kbps = perp_pkg::rate_kbps(perp_pkg::CODE_UNLIMITED);
      end else begin
         limit_kbps = raw;
      end
   end
endmodule // perp_rate_map

/* rtl/perp_phy_ctrl.sv */
`timescale 1ns/1ps
module perp_phy_ctrl (
   input  wire logic mclk,  // System clock
   input  wire logic rst,   // Synchronous reset
   perp_phy_if.ctl   pif    // Register side and diagnostic engine
);
   perp_pkg::perp_diag_t state_q;
   logic       short_q;
   logic [1:0] result_q;
   logic       flink_q;
   logic       psave_q;
   logic       loop_q;
   logic [8:0] cnt_q;
   logic       start_q;
   logic       go;

   // A rewrite of the enable bit while a test runs does not restart it
   assign go = pif.wr && pif.wdata[perp_pkg::EN_BIT] && (state_q == perp_pkg::PERP_IDLE);

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= perp_pkg::PERP_IDLE;
      end else begin
         case (state_q)
            perp_pkg::PERP_IDLE:    if (go) state_q <= perp_pkg::PERP_TESTING;
            perp_pkg::PERP_TESTING: if (pif.done) state_q <= perp_pkg::PERP_IDLE;
            default:                state_q <= perp_pkg::PERP_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         start_q <= 1'b0;
      end else begin
         start_q <= go;
      end
   end

   // Results only move when a test finishes, so stale reads stay stable
   always_ff @(posedge mclk) begin
      if (rst) begin
         short_q  <= 1'b0;
         result_q <= perp_pkg::RESULT_RST;
         cnt_q    <= perp_pkg::FCNT_RST;
      end else if (state_q == perp_pkg::PERP_TESTING && pif.done) begin
         short_q  <= pif.short10;
         result_q <= pif.result;
         cnt_q    <= pif.cnt_in;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         flink_q <= 1'b0;
         psave_q <= perp_pkg::PSAVE_RST;
         loop_q  <= 1'b0;
      end else if (pif.wr) begin
         flink_q <= pif.wdata[perp_pkg::FLINK_BIT];
         psave_q <= pif.wdata[perp_pkg::PSAVE_BIT];
         loop_q  <= pif.wdata[perp_pkg::LOOP_BIT];
      end
   end

   assign pif.status      = {short_q, result_q, state_q == perp_pkg::PERP_TESTING,
                             flink_q, psave_q, loop_q, cnt_q[8]};
   assign pif.fault_cnt   = cnt_q;
   assign pif.start       = start_q;
   assign pif.force_link  = flink_q;
   assign pif.pwrsave_off = psave_q;
   assign pif.remote_loop = loop_q;

   a_en_self_clear: assert property (@(posedge mclk) disable iff (rst)
      state_q == perp_pkg::PERP_TESTING && pif.done |=> !pif.status[perp_pkg::EN_BIT])
      else $error("test enable not cleared after completion");
   a_start_one_pulse: assert property (@(posedge mclk) disable iff (rst)
      start_q |-> pif.status[perp_pkg::EN_BIT] && !$past(start_q))
      else $error("start pulse not a single cycle of a running test");
   a_result_latched: assert property (@(posedge mclk) disable iff (rst)
      state_q == perp_pkg::PERP_TESTING && pif.done |=> result_q == $past(pif.result))
      else $error("test result not captured at completion");
endmodule // perp_phy_ctrl

/* rtl/perp_regs.sv */
`timescale 1ns/1ps
module perp_regs (
   input  wire logic        mclk,            // 250 MHz system clock
   input  wire logic        rst,             // Synchronous reset, active high
   input  wire logic [7:0]  reg_addr,        // Management register address
   input  wire logic        reg_wr,          // Management write strobe
   input  wire logic        reg_rd,          // Management read strobe
   input  wire logic [7:0]  reg_wdata,       // Management write data
   output logic      [7:0]  reg_rdata_q,     // Management read data
   input  wire logic        miim_sel,        // PHY view port: 0 = port 1, 1 = port 2
   input  wire logic        miim_wr,         // PHY view write strobe
   input  wire logic        miim_rd,         // PHY view read strobe
   input  wire logic [7:0]  miim_wdata,      // PHY view write data, same layout
   output logic      [7:0]  miim_rdata_q,    // PHY view read data
   input  wire logic [2:0]  ten_meg_speed,   // Per port: link runs at 10 Mbps
   input  wire logic        multi_q_en,      // Multiple transmit queues enabled
   output logic      [16:0] queue3_kbps_q [3], // Per port queue 3 limit, 0 = none
   output logic      [16:0] queue2_kbps_q [3], // Per port queue 2 limit, 0 = none
   output logic      [1:0]  diag_start_q,    // Per PHY cable test start pulse
   input  wire logic [1:0]  diag_done,       // Per PHY cable test done pulse
   input  wire logic [3:0]  diag_result,     // Per PHY result, port 2 in 3:2
   input  wire logic [1:0]  diag_short10,    // Per PHY near short seen
   input  wire logic [17:0] diag_count,      // Per PHY fault count, port 2 in 17:9
   output logic      [1:0]  force_link_q,    // Per PHY force link pass
   output logic      [1:0]  pwrsave_off_q,   // Per PHY power saving disabled
   output logic      [1:0]  remote_loop_q    // Per PHY remote loopback
);

   // ***************************************************************
   // Address helpers
   // ***************************************************************
   function automatic logic [7:0] rate_ofs(input int p);
      return (p == 0) ? perp_pkg::OFS_P1_RATE :
             (p == 1) ? perp_pkg::OFS_P2_RATE : perp_pkg::OFS_P3_RATE;
   endfunction

   function automatic logic [7:0] phy_ofs(input int p);
      return (p == 0) ? perp_pkg::OFS_P1_PHY : perp_pkg::OFS_P2_PHY;
   endfunction

   // ***************************************************************
   // Rate storage
   // ***************************************************************
   logic [7:0]  rate_q [3];
   logic [16:0] q3_lim [3];
   logic [16:0] q2_lim [3];

   for (genvar p = 0; p < 3; p++) begin : g_rate
      always_ff @(posedge mclk) begin
         if (rst) begin
            rate_q[p] <= perp_pkg::RATE_RST;
         end else if (reg_wr && reg_addr == rate_ofs(p)) begin
            rate_q[p] <= reg_wdata;
         end
      end

      perp_rate_map u_q3 (
         .code       (rate_q[p][perp_pkg::Q3_LSB +: 4]),
         .ten_meg    (ten_meg_speed[p]),
         .multi_q_en (multi_q_en),
         .limit_kbps (q3_lim[p])
      );

      perp_rate_map u_q2 (
         .code       (rate_q[p][perp_pkg::Q2_LSB +: 4]),
         .ten_meg    (ten_meg_speed[p]),
         .multi_q_en (multi_q_en),
         .limit_kbps (q2_lim[p])
      );

      always_ff @(posedge mclk) begin
         if (rst) begin
            queue3_kbps_q[p] <= 17'h00000;
            queue2_kbps_q[p] <= 17'h00000;
         end else begin
            queue3_kbps_q[p] <= q3_lim[p];
            queue2_kbps_q[p] <= q2_lim[p];
         end
      end
   end

   // ***************************************************************
   // PHY special control/status, shared by both access paths
   // ***************************************************************
   perp_phy_if pif [2] ();
   logic [7:0] phy_status [2];
   logic [8:0] phy_cnt    [2];
   logic [1:0] bus_hit;
   logic [1:0] miim_hit;

   for (genvar p = 0; p < 2; p++) begin : g_phy
      assign bus_hit[p]  = reg_wr && reg_addr == phy_ofs(p);
      // Management bus wins a same-cycle clash so one value lands
      assign miim_hit[p] = miim_wr && (miim_sel == 1'(p)) && !bus_hit[p];

      assign pif[p].wr      = bus_hit[p] || miim_hit[p];
      assign pif[p].wdata   = bus_hit[p] ? reg_wdata : miim_wdata;
      assign pif[p].done    = diag_done[p];
      assign pif[p].result  = diag_result[2*p +: 2];
      assign pif[p].short10 = diag_short10[p];
      assign pif[p].cnt_in  = diag_count[9*p +: 9];
      assign phy_status[p]  = pif[p].status;
      assign phy_cnt[p]     = pif[p].fault_cnt;

      perp_phy_ctrl u_ctrl (
         .mclk (mclk),
         .rst  (rst),
         .pif  (pif[p])
      );

      always_ff @(posedge mclk) begin
         if (rst) begin
            diag_start_q[p]  <= 1'b0;
            force_link_q[p]  <= 1'b0;
            pwrsave_off_q[p] <= perp_pkg::PSAVE_RST;
            remote_loop_q[p] <= 1'b0;
         end else begin
            diag_start_q[p]  <= pif[p].start;
            force_link_q[p]  <= pif[p].force_link;
            pwrsave_off_q[p] <= pif[p].pwrsave_off;
            remote_loop_q[p] <= pif[p].remote_loop;
         end
      end
   end

   // ***************************************************************
   // Read paths
   // ***************************************************************
   logic [7:0] rd_mux;

   always_comb begin
      if (reg_addr == perp_pkg::OFS_P1_RATE) begin
         rd_mux = rate_q[0];
      end else if (reg_addr == perp_pkg::OFS_P2_RATE) begin
         rd_mux = rate_q[1];
      end else if (reg_addr == perp_pkg::OFS_P3_RATE) begin
         rd_mux = rate_q[2];
      end else if (reg_addr == perp_pkg::OFS_P1_PHY) begin
         rd_mux = phy_status[0];
      end else if (reg_addr == perp_pkg::OFS_P2_PHY) begin
         rd_mux = phy_status[1];
      end else if (reg_addr == perp_pkg::OFS_P1_FCNT) begin
         rd_mux = phy_cnt[0][7:0];
      end else if (reg_addr == perp_pkg::OFS_P2_FCNT) begin
         rd_mux = phy_cnt[1][7:0];
      end else begin
         rd_mux = 8'h00;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_q <= rd_mux;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         miim_rdata_q <= 8'h00;
      end else if (miim_rd) begin
         miim_rdata_q <= phy_status[miim_sel];
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   a_rate_write_read: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == perp_pkg::OFS_P2_RATE ##1 reg_rd && !reg_wr
         && reg_addr == perp_pkg::OFS_P2_RATE |=> reg_rdata_q == $past(reg_wdata, 2))
      else $error("port 2 rate register did not read back");
   a_ten_meg_cap: assert property (@(posedge mclk) disable iff (rst)
      ten_meg_speed[0] |=> queue3_kbps_q[0] <= perp_pkg::TEN_MEG_KBPS
         && queue2_kbps_q[0] <= perp_pkg::TEN_MEG_KBPS)
      else $error("limit above 10 Mbps kept at 10 Mbps link speed");
   a_single_queue_off: assert property (@(posedge mclk) disable iff (rst)
      !multi_q_en |=> queue3_kbps_q[1] == 17'h00000 && queue2_kbps_q[1] == 17'h00000)
      else $error("queue 2/3 limit active in single queue mode");
   a_code_e_eighty: assert property (@(posedge mclk) disable iff (rst)
      multi_q_en && !ten_meg_speed[2] && rate_q[2][perp_pkg::Q3_LSB +: 4] == 4'hE
         |=> queue3_kbps_q[2] == 17'h13880)
      else $error("code E did not give 80 Mbps");
   a_rsvd_reads_zero: assert property (@(posedge mclk) disable iff (rst)
      reg_rd && (reg_addr == perp_pkg::OFS_P3_PHY_RSVD
         || reg_addr == perp_pkg::OFS_P3_FCNT_RSV) |=> reg_rdata_q == 8'h00)
      else $error("reserved port 3 PHY offset read non-zero");
   a_views_agree: assert property (@(posedge mclk) disable iff (rst)
      miim_wr && !miim_sel && !bus_hit[0] ##1 reg_rd && !reg_wr && !miim_wr
         && reg_addr == perp_pkg::OFS_P1_PHY
         |=> reg_rdata_q[perp_pkg::LOOP_BIT] == $past(miim_wdata[perp_pkg::LOOP_BIT], 2))
      else $error("PHY view write not seen on management bus");
   a_psave_follows: assert property (@(posedge mclk) disable iff (rst)
      bus_hit[1] |=> ##1 pwrsave_off_q[1] == $past(reg_wdata[perp_pkg::PSAVE_BIT], 2))
      else $error("power saving output not following its bit");
   a_start_on_write: assert property (@(posedge mclk) disable iff (rst)
      bus_hit[0] && reg_wdata[perp_pkg::EN_BIT] && !phy_status[0][perp_pkg::EN_BIT]
         |=> ##1 diag_start_q[0])
      else $error("cable test did not start on enable write");
   a_count_hi_bit: assert property (@(posedge mclk) disable iff (rst)
      diag_done[1] && phy_status[1][perp_pkg::EN_BIT]
         |=> phy_status[1][perp_pkg::CNT8_BIT] == $past(diag_count[17]))
      else $error("status bit 0 not loaded with fault count bit 8");

endmodule // perp_regs

/* dv/test_port_egress_rate_phy_ctrl_regs.sv */
`timescale 1ns/1ps
module test_port_egress_rate_phy_ctrl_regs;
   // ************************************************
   // Stimulus and observed signals
   // ************************************************
   logic        mclk          = 1'b0;
   logic        rst           = 1'b1;
   logic [7:0]  reg_addr      = 8'h00;
   logic        reg_wr        = 1'b0;
   logic        reg_rd        = 1'b0;
   logic [7:0]  reg_wdata     = 8'h00;
   logic [7:0]  reg_rdata_q;
   logic        miim_sel      = 1'b0;
   logic        miim_wr       = 1'b0;
   logic        miim_rd       = 1'b0;
   logic [7:0]  miim_wdata    = 8'h00;
   logic [7:0]  miim_rdata_q;
   logic [2:0]  ten_meg_speed = 3'h0;
   logic        multi_q_en    = 1'b1;
   logic [16:0] q3_kbps [3];
   logic [16:0] q2_kbps [3];
   logic [1:0]  diag_start_q;
   logic [1:0]  diag_done     = 2'h0;
   logic [3:0]  diag_result   = 4'h0;
   logic [1:0]  diag_short10  = 2'h0;
   logic [17:0] diag_count    = 18'h00000;
   logic [1:0]  force_link_q;
   logic [1:0]  pwrsave_off_q;
   logic [1:0]  remote_loop_q;
   integer      n_fail        = 0;
   integer      n_checks      = 0;
   integer      seed          = 32'hC2ED;
   int          rate_m [3]    = '{0, 0, 0};
   int          phy_m [2]     = '{4, 4};
   int          fcnt_m [2]    = '{0, 0};
   int          starts [2]    = '{0, 0};
   int          tests [2]     = '{0, 0};
   int          kt [16]       = '{0, 64, 128, 256, 512, 1000, 2000, 4000, 8000, 16000,
                                  32000, 48000, 64000, 72000, 80000, 88000};

   always #2 mclk = ~mclk;

   perp_regs u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .miim_sel(miim_sel), .miim_wr(miim_wr), .miim_rd(miim_rd), .miim_wdata(miim_wdata),
      .miim_rdata_q(miim_rdata_q), .ten_meg_speed(ten_meg_speed), .multi_q_en(multi_q_en),
      .queue3_kbps_q(q3_kbps), .queue2_kbps_q(q2_kbps), .diag_start_q(diag_start_q),
      .diag_done(diag_done), .diag_result(diag_result), .diag_short10(diag_short10),
      .diag_count(diag_count), .force_link_q(force_link_q), .pwrsave_off_q(pwrsave_off_q),
      .remote_loop_q(remote_loop_q));

   // Counts start pulses; a level held too long shows up as extra starts
   always @(posedge mclk)
      for (int p = 0; p < 2; p++)
         if (diag_start_q[p] === 1'b1) starts[p]++;

   // ************************************************
   // Model and bus tasks
   // ************************************************
   task automatic chk(input string nm, input int e, input logic [16:0] g);
      n_checks++;
      if ({15'h0000, g} !== e) begin
         $display("wrong value %s expected %0h seen %0h", nm, e, g);
         n_fail++;
      end
   endtask

   function automatic int lim(input int c, input bit ten);
      if (!multi_q_en || (ten && kt[c] > 10000)) return 0;
      return kt[c];
   endfunction

   function automatic int exp_rd(input logic [7:0] a);
      int p;
      p = a[5:4] - 1;
      if (a[7:6] != 2'h0 || a[5:4] == 2'h0) return 0;
      case (a[3:0])
         4'h9: return rate_m[p];
         4'hA: return p < 2 ? phy_m[p] : 0;
         4'hB: return p < 2 ? fcnt_m[p] : 0;
         default: return 0;
      endcase
   endfunction

   // One access on the register bus or, with mi set, on the PHY view
   task automatic acc(input bit mi, input bit w, input logic [7:0] a, input int d);
      @(posedge mclk);
      reg_addr <= a;
      miim_sel <= a[5];
      reg_wdata <= d[7:0];
      miim_wdata <= d[7:0];
      reg_wr <= w & !mi;
      miim_wr <= w & mi;
      reg_rd <= !w & !mi;
      miim_rd <= !w & mi;
      @(posedge mclk);
      {reg_wr, miim_wr, reg_rd, miim_rd} <= 4'h0;
      #1;
      if (!w) chk("read data", d, mi ? miim_rdata_q : reg_rdata_q);
   endtask

   // Model side of a write; read-only status bits keep their old value
   function automatic void note_wr(input logic [7:0] a, input int d);
      if (a[3:0] == 4'h9 && a[5:4] != 2'h0) rate_m[a[5:4] - 1] = d & 255;
      if (a[3:0] == 4'hA && a[5:4] inside {1, 2})
         phy_m[a[5:4] - 1] = (phy_m[a[5:4] - 1] & 'hE1) | (d & 'h1E);
   endfunction

   task automatic put(input bit mi, input logic [7:0] a, input int d);
      acc(mi, 1'b1, a, d);
      note_wr(a, d);
   endtask

   // Write on either path, then a bus read of it on the very next cycle
   task automatic wr_rd(input bit mi, input logic [7:0] a, input int d);
      @(posedge mclk);
      reg_addr   <= a;
      miim_sel   <= a[5];
      reg_wdata  <= d[7:0];
      miim_wdata <= d[7:0];
      reg_wr     <= !mi;
      miim_wr    <= mi;
      @(posedge mclk);
      reg_wr     <= 1'b0;
      miim_wr    <= 1'b0;
      reg_rd     <= 1'b1;
      note_wr(a, d);
      @(posedge mclk);
      reg_rd     <= 1'b0;
      #1;
      chk("back to back read", exp_rd(a), reg_rdata_q);
   endtask

   task automatic outs();
      repeat (3) @(posedge mclk);
      #1;
      for (int p = 0; p < 3; p++) begin
         chk("queue3 limit", lim(rate_m[p] >> 4, ten_meg_speed[p]), q3_kbps[p]);
         chk("queue2 limit", lim(rate_m[p] & 15, ten_meg_speed[p]), q2_kbps[p]);
      end
      chk("phy controls", {phy_m[1][3:1], phy_m[0][3:1]}, {force_link_q[1],
          pwrsave_off_q[1], remote_loop_q[1], force_link_q[0], pwrsave_off_q[0],
          remote_loop_q[0]});
   endtask

   // A full cable test on one PHY, started and read through either path
   task automatic diag(input bit mi, input int p);
      logic [7:0] a;
      logic [8:0] cnt;
      logic [1:0] res;
      logic       sh;
      a = 8'(8'h1A + 16 * p);
      cnt = 9'($random(seed));
      res = 2'($random(seed));
      sh = 1'($random(seed));
      put(mi, a, phy_m[p] | 'h10);
      tests[p]++;
      acc(!mi, 1'b0, a, phy_m[p]);
      @(posedge mclk);
      diag_done[p] <= 1'b1;
      diag_result[2 * p +: 2] <= res;
      diag_short10[p] <= sh;
      diag_count[9 * p +: 9] <= cnt;
      @(posedge mclk);
      // Engine lines change once done drops, so stale values cannot pass
      diag_done <= 2'h0;
      diag_result <= ~diag_result;
      diag_short10 <= ~diag_short10;
      diag_count <= ~diag_count;
      phy_m[p] = {sh, res, 1'b0, phy_m[p][3:1], cnt[8]};
      fcnt_m[p] = cnt[7:0];
      acc(mi, 1'b0, a, phy_m[p]);
      acc(1'b0, 1'b0, 8'(a + 1), fcnt_m[p]);
      chk("start pulses", tests[p], 17'(starts[p]));
      outs();
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ************************************************
   // Sequence
   // ************************************************
   initial begin
      #200000;
      n_fail++;
      complete_run();
   end

   initial begin
      logic [7:0] ra;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      outs();
      for (int a = 8'h18; a < 8'h3D; a++) acc(1'b0, 1'b0, 8'(a), exp_rd(8'(a)));
      for (int c = 0; c < 16; c++) begin
         put(1'b0, 8'(8'h19 + 16 * (c % 3)), c * 17 ^ 15);
         outs();
      end
      // Done while idle must leave results untouched
      @(posedge mclk);
      diag_done <= 2'h3;
      diag_result <= 4'hF;
      diag_short10 <= 2'h3;
      diag_count <= 18'h3FFFF;
      @(posedge mclk);
      diag_done <= 2'h0;
      acc(1'b0, 1'b0, 8'h1A, phy_m[0]);
      acc(1'b1, 1'b0, 8'h2A, phy_m[1]);
      for (int i = 0; i < 60; i++) begin
         @(posedge mclk);
         ten_meg_speed <= 3'($random(seed));
         multi_q_en <= (i % 8) != 7;
         ra = 8'(8'h19 + 16 * (i % 3));
         put(1'b0, ra, $random(seed));
         put(i[0], 8'(8'h1A + 16 * (i % 2)), $random(seed) & 'hEF);
         wr_rd(i[0], i[0] ? 8'h1A : 8'h29, $random(seed) & 'hEF);
         outs();
         acc(1'b0, 1'b0, ra, exp_rd(ra));
         acc(!i[0], 1'b0, 8'(8'h1A + 16 * (i % 2)), phy_m[i % 2]);
         if (i % 6 == 0) diag(i[1], i % 4 == 0 ? 0 : 1);
      end
      put(1'b0, 8'h3A, 'hFF);
      put(1'b0, 8'h3B, 'hFF);
      acc(1'b0, 1'b0, 8'h3A, 0);
      acc(1'b0, 1'b0, 8'h3B, 0);
      outs();
      complete_run();
   end
endmodule // test_port_egress_rate_phy_ctrl_regs
